// >>> pmcfg_consts.svh
//////////////////////////////////////////////////////////////////////////////
// Purpose: Offsets, field positions, defaults and figures of the mode config bank
// Assumes: Byte registers reached by the I2C target engine's register port
// Notes: Reset bytes below are the defaults the programmable bits normally hold
// Operation
// RULE_01: Three config bytes fully readable and writable, reads return stored value.
// RULE_02: Mode-0 part-2 bits 7:4 hold always-on regulator code, default 0100.
// RULE_03: Mode-0 part-2 bit 3 enables core buck, default on.
// RULE_04: Mode-0 part-2 bit 2 enables system buck, default on.
// RULE_05: Mode-0 part-2 bit 1 enables always-on regulator, default on.
// RULE_06: Mode-0 part-2 bit 0 enables system linear regulator, default on.
// RULE_07: Mode-0 watchdog field: off, 16 s, 32 s, 64 s; default off.
// RULE_08: Mode-0 part-3 bit 5 adds 1.2 V linear offset, default set.
// RULE_09: Mode-0 part-3 bits 4:0 linear base code, 1.500 V up, default 11001.
// RULE_10: Mode-1 part-0 bit 7 selects ship mode in mode 1, default clear.
// RULE_11: Mode-1 part-0 bit 6 picks pins or register bits as mode source.
// RULE_12: Mode-1 part-0 bits 5:0 core buck code, 0.500 V up, default 011100.
// RULE_13: Reset defaults come from one-time programmable bits, not constants.
// RULE_14: Only fields of the selected mode setting drive the regulators; in modes 2 and 3 the voltages still decode mode 1 fields.
//////////////////////////////////////////////////////////////////////////////
`ifndef PMCFG_CONSTS_SVH
`define PMCFG_CONSTS_SVH

`define PMCFG_ADDR_M0P2 8'h24
`define PMCFG_ADDR_M0P3 8'h25
`define PMCFG_ADDR_M1P0 8'h26
`define PMCFG_RD_UNMAPPED 8'h00

`define PMCFG_M0P2_AON_HI 7
`define PMCFG_M0P2_AON_LO 4
`define PMCFG_M0P2_CORE_EN 3
`define PMCFG_M0P2_SYS_EN 2
`define PMCFG_M0P2_AON_EN 1
`define PMCFG_M0P2_LIN_EN 0
`define PMCFG_M0P3_WD_HI 7
`define PMCFG_M0P3_WD_LO 6
`define PMCFG_M0P3_OFS 5
`define PMCFG_M0P3_LIN_HI 4
`define PMCFG_M0P3_LIN_LO 0
`define PMCFG_M1P0_SHIP 7
`define PMCFG_M1P0_SRC 6
`define PMCFG_M1P0_CORE_HI 5
`define PMCFG_M1P0_CORE_LO 0

`define PMCFG_RST_M0P2 8'h4f
`define PMCFG_RST_M0P3 8'h39
`define PMCFG_RST_M1P0 8'h1c

`define PMCFG_AON_BASE_MV 16'h06a4
`define PMCFG_AON_MAX_CODE 4'h8
`define PMCFG_LIN_BASE_MV 16'h05dc
`define PMCFG_LIN_MAX_CODE 5'h18
`define PMCFG_LIN_OFS_MV 16'h04b0
`define PMCFG_CORE_BASE_MV 16'h01f4
`define PMCFG_CORE_MAX_CODE 6'h28
`define PMCFG_CORE_TOP_CODE 6'h3f
`define PMCFG_CORE_TOP_MV 16'h0708
`define PMCFG_STEP_MV 16'h0019
`define PMCFG_WD_OFF_S 8'h00
`define PMCFG_WD_16_S 8'h10
`define PMCFG_WD_32_S 8'h20
`define PMCFG_WD_64_S 8'h40

`endif

// >>> pmcfg_pkg.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Types shared by the mode config bank
// Assumes: Constants live in pmcfg_consts.svh
// Notes: One-hot codes written out
//////////////////////////////////////////////////////////////////////////////
package pmcfg_pkg;
   typedef enum logic [2:0] {
      PMCFG_MODE_0 = 3'h1,
      PMCFG_MODE_1 = 3'h2,
      PMCFG_MODE_HI = 3'h4
   } pmcfg_mode_t;

   typedef logic [7:0] pmcfg_byte_t;
endpackage : pmcfg_pkg

// >>> pmcfg_mode_if.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Carries mode source settings and the selected mode between modules
// Assumes: Single clock domain
// Notes: None
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`default_nettype none
interface pmcfg_mode_if;
   import pmcfg_pkg::*;
   logic src_pins_m0;
   logic src_pins_m1;
   logic [1:0] active_mode;
   pmcfg_mode_t mode_state;

   modport sel (input src_pins_m0, input src_pins_m1, output active_mode, output mode_state);
   modport user (output src_pins_m0, output src_pins_m1, input active_mode, input mode_state);
endinterface : pmcfg_mode_if
`default_nettype wire

// >>> pmcfg_mode_sel.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Chooses the active mode setting from pins or register bits
// Assumes: Select pins are asynchronous to clk
// Notes: Source bit of the currently active mode decides the next choice
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`default_nettype none
module pmcfg_mode_sel
   import pmcfg_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic mode_select_pin_a,
   input wire logic mode_select_pin_b,
   input wire logic mode_select_bit_a,
   input wire logic mode_select_bit_b,
   input wire logic src_pins_hi,
   pmcfg_mode_if.sel mif
);
   logic [1:0] pin_meta_reg;
   logic [1:0] pin_sync_reg;
   logic [1:0] mode_reg;
   logic [1:0] mode_next;
   pmcfg_mode_t state_reg;
   pmcfg_mode_t state_next;
   logic use_pins;

   // Two flops before the pins are looked at
   always_ff @(posedge clk) begin
      pin_meta_reg <= {mode_select_pin_b, mode_select_pin_a};
      pin_sync_reg <= pin_meta_reg;
   end

   // RULE_11 source of mode control
   assign use_pins = (state_reg == PMCFG_MODE_0) ? mif.src_pins_m0 :
                     (state_reg == PMCFG_MODE_1) ? mif.src_pins_m1 : src_pins_hi;
   assign mode_next = use_pins ? pin_sync_reg : {mode_select_bit_b, mode_select_bit_a};

   always_comb begin
      case (mode_next)
         2'h0: state_next = PMCFG_MODE_0;
         2'h1: state_next = PMCFG_MODE_1;
         default: state_next = PMCFG_MODE_HI;
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         mode_reg <= 2'h0;
         state_reg <= PMCFG_MODE_0;
      end else begin
         mode_reg <= mode_next;
         state_reg <= state_next;
      end
   end

   assign mif.active_mode = mode_reg;
   assign mif.mode_state = state_reg;
endmodule : pmcfg_mode_sel
`default_nettype wire

// >>> pmcfg_regs.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Mode setting 0 parts 2-3 and mode setting 1 part 0 config bytes
// Assumes: I2C target engine presents single-cycle byte read/write strobes
// Notes: Fields held in neighbouring bytes arrive as plain inputs
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`default_nettype none
`include "pmcfg_consts.svh"
module pmcfg_regs
   import pmcfg_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   // Register port from the I2C target engine
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wr_data,
   output logic [7:0] reg_rd_data,
   output logic reg_hit,
   // One-time programmable defaults, stable while reset is high
   input wire logic [7:0] otp_m0p2,
   input wire logic [7:0] otp_m0p3,
   input wire logic [7:0] otp_m1p0,
   // Mode control
   input wire logic mode_select_pin_a,
   input wire logic mode_select_pin_b,
   input wire logic mode_select_bit_a,
   input wire logic mode_select_bit_b,
   // Neighbouring bytes of the two mode settings, and the source bit of modes 2 and 3
   input wire logic nb_ship_m0,
   input wire logic nb_src_pins_m0,
   input wire logic [5:0] nb_core_code_m0,
   input wire logic [3:0] nb_aon_code_m1,
   input wire logic [3:0] nb_enables_m1,
   input wire logic [1:0] nb_wd_m1,
   input wire logic nb_lin_ofs_m1,
   input wire logic [4:0] nb_lin_code_m1,
   input wire logic nb_src_pins_hi,
   // Applied settings
   output logic [1:0] active_mode,
   output logic mode_in_scope,
   output logic core_buck_en,
   output logic system_buck_en,
   output logic aon_reg_en,
   output logic sys_linear_en,
   output logic ship_mode,
   output logic [1:0] watchdog_period,
   output logic [7:0] watchdog_seconds,
   output logic [15:0] core_buck_mv,
   output logic [15:0] aon_reg_mv,
   output logic [15:0] sys_linear_mv
);
   pmcfg_byte_t mode0_part2_cfg_reg;
   pmcfg_byte_t mode0_part2_cfg_next;
   pmcfg_byte_t mode0_part3_cfg_reg;
   pmcfg_byte_t mode0_part3_cfg_next;
   pmcfg_byte_t mode1_part0_cfg_reg;
   pmcfg_byte_t mode1_part0_cfg_next;
   pmcfg_byte_t rd_data_reg;
   pmcfg_byte_t rd_data_next;

   pmcfg_mode_if mif();

   //////////////////////////////////////////////////////////////////////////////
   // Field views of the stored bytes

   logic [3:0] aon_reg_voltage_code_m0;
   logic core_buck_enable_m0;
   logic system_buck_enable_m0;
   logic aon_reg_enable_m0;
   logic sys_linear_enable_m0;
   logic [1:0] watchdog_period_m0;
   logic sys_linear_offset_m0;
   logic [4:0] sys_linear_voltage_code_m0;
   logic ship_mode_m1;
   logic mode_source_pins_m1;
   logic [5:0] core_buck_voltage_code_m1;

   // RULE_02 always-on code field
   assign aon_reg_voltage_code_m0 = mode0_part2_cfg_reg[`PMCFG_M0P2_AON_HI:`PMCFG_M0P2_AON_LO];
   // RULE_03 core buck enable
   assign core_buck_enable_m0 = mode0_part2_cfg_reg[`PMCFG_M0P2_CORE_EN];
   // RULE_04 system buck enable
   assign system_buck_enable_m0 = mode0_part2_cfg_reg[`PMCFG_M0P2_SYS_EN];
   // RULE_05 always-on enable
   assign aon_reg_enable_m0 = mode0_part2_cfg_reg[`PMCFG_M0P2_AON_EN];
   // RULE_06 linear enable
   assign sys_linear_enable_m0 = mode0_part2_cfg_reg[`PMCFG_M0P2_LIN_EN];
   // RULE_07 watchdog field
   assign watchdog_period_m0 = mode0_part3_cfg_reg[`PMCFG_M0P3_WD_HI:`PMCFG_M0P3_WD_LO];
   // RULE_08 offset select
   assign sys_linear_offset_m0 = mode0_part3_cfg_reg[`PMCFG_M0P3_OFS];
   // RULE_09 linear base code
   assign sys_linear_voltage_code_m0 = mode0_part3_cfg_reg[`PMCFG_M0P3_LIN_HI:`PMCFG_M0P3_LIN_LO];
   // RULE_10 ship mode bit
   assign ship_mode_m1 = mode1_part0_cfg_reg[`PMCFG_M1P0_SHIP];
   // RULE_11 mode source bit
   assign mode_source_pins_m1 = mode1_part0_cfg_reg[`PMCFG_M1P0_SRC];
   // RULE_12 core buck code field
   assign core_buck_voltage_code_m1 = mode1_part0_cfg_reg[`PMCFG_M1P0_CORE_HI:`PMCFG_M1P0_CORE_LO];

   //////////////////////////////////////////////////////////////////////////////
   // Register access decode

   logic hit_m0p2;
   logic hit_m0p3;
   logic hit_m1p0;
   logic wr_m0p2;
   logic wr_m0p3;
   logic wr_m1p0;

   assign hit_m0p2 = (reg_addr == `PMCFG_ADDR_M0P2);
   assign hit_m0p3 = (reg_addr == `PMCFG_ADDR_M0P3);
   assign hit_m1p0 = (reg_addr == `PMCFG_ADDR_M1P0);
   assign reg_hit = hit_m0p2 | hit_m0p3 | hit_m1p0;
   assign wr_m0p2 = reg_wr_en & hit_m0p2;
   assign wr_m0p3 = reg_wr_en & hit_m0p3;
   assign wr_m1p0 = reg_wr_en & hit_m1p0;

   // RULE_01 whole byte written
   assign mode0_part2_cfg_next = wr_m0p2 ? reg_wr_data : mode0_part2_cfg_reg;
   assign mode0_part3_cfg_next = wr_m0p3 ? reg_wr_data : mode0_part3_cfg_reg;
   assign mode1_part0_cfg_next = wr_m1p0 ? reg_wr_data : mode1_part0_cfg_reg;

   // RULE_01 read back stored byte
   assign rd_data_next = !reg_rd_en ? rd_data_reg :
                         hit_m0p2 ? mode0_part2_cfg_reg :
                         hit_m0p3 ? mode0_part3_cfg_reg :
                         hit_m1p0 ? mode1_part0_cfg_reg : `PMCFG_RD_UNMAPPED;

   // RULE_13 defaults loaded from programmable bits
   always_ff @(posedge clk) begin
      if (reset) begin
         mode0_part2_cfg_reg <= otp_m0p2;
         mode0_part3_cfg_reg <= otp_m0p3;
         mode1_part0_cfg_reg <= otp_m1p0;
         rd_data_reg <= `PMCFG_RD_UNMAPPED;
      end else begin
         mode0_part2_cfg_reg <= mode0_part2_cfg_next;
         mode0_part3_cfg_reg <= mode0_part3_cfg_next;
         mode1_part0_cfg_reg <= mode1_part0_cfg_next;
         rd_data_reg <= rd_data_next;
      end
   end

   assign reg_rd_data = rd_data_reg;

   //////////////////////////////////////////////////////////////////////////////
   // Mode selection

   assign mif.src_pins_m0 = nb_src_pins_m0;
   assign mif.src_pins_m1 = mode_source_pins_m1;

   pmcfg_mode_sel u_mode_sel (
      .clk(clk),
      .reset(reset),
      .mode_select_pin_a(mode_select_pin_a),
      .mode_select_pin_b(mode_select_pin_b),
      .mode_select_bit_a(mode_select_bit_a),
      .mode_select_bit_b(mode_select_bit_b),
      .src_pins_hi(nb_src_pins_hi),
      .mif(mif.sel)
   );

   //////////////////////////////////////////////////////////////////////////////
   // Code to millivolt decode; out-of-range codes clamp as the tables do, except core code 3f, which gives 1800 mV

   function automatic logic [15:0] aon_mv(input logic [3:0] code);
      logic [3:0] c;
      c = (code > `PMCFG_AON_MAX_CODE) ? `PMCFG_AON_MAX_CODE : code;
      aon_mv = `PMCFG_AON_BASE_MV + 16'({12'h000, c} * `PMCFG_STEP_MV);
   endfunction : aon_mv

   function automatic logic [15:0] lin_mv(input logic [4:0] code, input logic ofs);
      logic [4:0] c;
      c = (code > `PMCFG_LIN_MAX_CODE) ? `PMCFG_LIN_MAX_CODE : code;
      lin_mv = `PMCFG_LIN_BASE_MV + 16'({11'h000, c} * `PMCFG_STEP_MV) +
               (ofs ? `PMCFG_LIN_OFS_MV : 16'h0000);
   endfunction : lin_mv

   function automatic logic [15:0] core_mv(input logic [5:0] code);
      logic [5:0] c;
      c = (code > `PMCFG_CORE_MAX_CODE) ? `PMCFG_CORE_MAX_CODE : code;
      if (code == `PMCFG_CORE_TOP_CODE) begin
         core_mv = `PMCFG_CORE_TOP_MV;
      end else begin
         core_mv = `PMCFG_CORE_BASE_MV + 16'({10'h000, c} * `PMCFG_STEP_MV);
      end
   endfunction : core_mv

   function automatic logic [7:0] wd_seconds(input logic [1:0] code);
      case (code)
         2'h1: wd_seconds = `PMCFG_WD_16_S;
         2'h2: wd_seconds = `PMCFG_WD_32_S;
         2'h3: wd_seconds = `PMCFG_WD_64_S;
         default: wd_seconds = `PMCFG_WD_OFF_S;
      endcase
   endfunction : wd_seconds

   //////////////////////////////////////////////////////////////////////////////
   // Apply the selected mode setting

   logic sel_m0;
   logic sel_m1;
   logic [3:0] en_sel;
   logic [3:0] aon_code_sel;
   logic [5:0] core_code_sel;
   logic [4:0] lin_code_sel;
   logic lin_ofs_sel;
   logic [1:0] wd_sel;
   logic ship_sel;
   logic [3:0] en_next;
   logic [1:0] wd_next;
   logic ship_next;
   logic [7:0] wd_sec_next;
   logic [7:0] wd_sec_reg;
   logic [15:0] core_mv_next;
   logic [15:0] aon_mv_next;
   logic [15:0] lin_mv_next;
   logic [3:0] en_reg;
   logic [1:0] wd_reg;
   logic ship_reg;
   logic [15:0] core_mv_reg;
   logic [15:0] aon_mv_reg;
   logic [15:0] lin_mv_reg;

   assign sel_m0 = (mif.mode_state == PMCFG_MODE_0);
   assign sel_m1 = (mif.mode_state == PMCFG_MODE_1);

   // RULE_14 pick mode 0 fields in mode 0, mode 1 fields in every other mode
   assign en_sel = sel_m0 ? {core_buck_enable_m0, system_buck_enable_m0,
                             aon_reg_enable_m0, sys_linear_enable_m0} : nb_enables_m1;
   assign aon_code_sel = sel_m0 ? aon_reg_voltage_code_m0 : nb_aon_code_m1;
   assign core_code_sel = sel_m0 ? nb_core_code_m0 : core_buck_voltage_code_m1;
   assign lin_code_sel = sel_m0 ? sys_linear_voltage_code_m0 : nb_lin_code_m1;
   assign lin_ofs_sel = sel_m0 ? sys_linear_offset_m0 : nb_lin_ofs_m1;
   assign wd_sel = sel_m0 ? watchdog_period_m0 : nb_wd_m1;
   assign ship_sel = sel_m0 ? nb_ship_m0 : ship_mode_m1;

   // Modes 2 and 3 live in other banks; hold enables, watchdog and ship mode off rather than guess
   assign en_next = (sel_m0 | sel_m1) ? en_sel : 4'h0;
   assign wd_next = (sel_m0 | sel_m1) ? wd_sel : 2'h0;
   assign ship_next = (sel_m0 | sel_m1) ? ship_sel : 1'b0;
   // Seconds decoded ahead of the flop so the output comes straight from a register
   assign wd_sec_next = wd_seconds(wd_next);
   assign core_mv_next = core_mv(core_code_sel);
   assign aon_mv_next = aon_mv(aon_code_sel);
   assign lin_mv_next = lin_mv(lin_code_sel, lin_ofs_sel);

   always_ff @(posedge clk) begin
      if (reset) begin
         en_reg <= 4'h0;
         wd_reg <= 2'h0;
         wd_sec_reg <= `PMCFG_WD_OFF_S;
         ship_reg <= 1'b0;
         core_mv_reg <= 16'h0000;
         aon_mv_reg <= 16'h0000;
         lin_mv_reg <= 16'h0000;
      end else begin
         en_reg <= en_next;
         wd_reg <= wd_next;
         wd_sec_reg <= wd_sec_next;
         ship_reg <= ship_next;
         core_mv_reg <= core_mv_next;
         aon_mv_reg <= aon_mv_next;
         lin_mv_reg <= lin_mv_next;
      end
   end

   assign active_mode = mif.active_mode;
   assign mode_in_scope = sel_m0 | sel_m1;
   assign core_buck_en = en_reg[3];
   assign system_buck_en = en_reg[2];
   assign aon_reg_en = en_reg[1];
   assign sys_linear_en = en_reg[0];
   assign ship_mode = ship_reg;
   assign watchdog_period = wd_reg;
   assign watchdog_seconds = wd_sec_reg;
   assign core_buck_mv = core_mv_reg;
   assign aon_reg_mv = aon_mv_reg;
   assign sys_linear_mv = lin_mv_reg;
endmodule : pmcfg_regs
`default_nettype wire

// >>> pmcfg_regs_properties.sv
// Purpose: Port properties of the mode config bank
// Assumes: One clock, synchronous reset
// Notes: Field checks tie a write to the mode seen when it lands
////////////////////////////////////////
`timescale 1ns/1ps
`default_nettype none
module pmcfg_regs_properties (
   input wire logic clk,
   input wire logic reset,
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wr_data,
   input wire logic [7:0] reg_rd_data,
   input wire logic reg_hit,
   input wire logic [3:0] nb_enables_m1,
   input wire logic [1:0] active_mode,
   input wire logic core_buck_en,
   input wire logic system_buck_en,
   input wire logic aon_reg_en,
   input wire logic sys_linear_en,
   input wire logic ship_mode,
   input wire logic [1:0] watchdog_period,
   input wire logic [15:0] core_buck_mv,
   input wire logic [15:0] aon_reg_mv,
   input wire logic [15:0] sys_linear_mv
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   function automatic logic [15:0] steps(input logic [5:0] c, input logic [5:0] top);
      return 16'h0019 * {10'h000, (c > top) ? top : c};
   endfunction : steps
   // Write taken, then the mode that applies it
   sequence s_wr_m(a, m);
      (reg_wr_en && reg_addr == a) ##1 (active_mode == m);
   endsequence
   rd_back_a: assert property (
      (reg_wr_en && reg_hit) ##1 (reg_rd_en && !reg_wr_en && reg_addr == $past(reg_addr))
      |=> reg_rd_data == $past(reg_wr_data, 2)) else $error("read back mismatch");
   unmapped_rd_a: assert property (
      reg_rd_en && !reg_hit |=> reg_rd_data == 8'h00) else $error("unmapped read not zero");
   rd_hold_a: assert property (
      !reg_rd_en |=> $stable(reg_rd_data)) else $error("read data moved");
   m0_enables_a: assert property (
      s_wr_m(8'h24, 2'h0) |=> {core_buck_en, system_buck_en, aon_reg_en, sys_linear_en}
      == $past(reg_wr_data[3:0], 2)) else $error("mode 0 enables wrong");
   aon_code_a: assert property (
      s_wr_m(8'h24, 2'h0) |=> aon_reg_mv == 16'h06a4
      + steps({2'h0, $past(reg_wr_data[7:4], 2)}, 6'h08)) else $error("aon voltage wrong");
   wd_code_a: assert property (
      s_wr_m(8'h25, 2'h0) |=> watchdog_period == $past(reg_wr_data[7:6], 2))
      else $error("watchdog code wrong");
   lin_mv_a: assert property (
      s_wr_m(8'h25, 2'h0) |=> sys_linear_mv == 16'h05dc
      + steps({1'b0, $past(reg_wr_data[4:0], 2)}, 6'h18)
      + ($past(reg_wr_data[5], 2) ? 16'h04b0 : 16'h0000)) else $error("linear voltage wrong");
   m1_fields_a: assert property (
      s_wr_m(8'h26, 2'h1) |=> ship_mode == $past(reg_wr_data[7], 2)
      && core_buck_mv == (($past(reg_wr_data[5:0], 2) == 6'h3f) ? 16'h0708
      : 16'h01f4 + steps($past(reg_wr_data[5:0], 2), 6'h28))) else $error("mode 1 fields wrong");
   m1_enables_a: assert property (
      active_mode == 2'h1 |=> {core_buck_en, system_buck_en, aon_reg_en, sys_linear_en}
      == $past(nb_enables_m1)) else $error("mode 1 enables wrong");
endmodule : pmcfg_regs_properties
bind pmcfg_regs pmcfg_regs_properties i_props (.clk, .reset, .reg_wr_en, .reg_rd_en, .reg_addr,
   .reg_wr_data, .reg_rd_data, .reg_hit, .nb_enables_m1, .active_mode, .core_buck_en,
   .system_buck_en, .aon_reg_en, .sys_linear_en, .ship_mode, .watchdog_period, .core_buck_mv,
   .aon_reg_mv, .sys_linear_mv);
`default_nettype wire

// >>> pmcfg_host_model.sv
// Purpose: Host model issuing register bytes
// Assumes: Called 1 ns after a rising edge
// Notes: Strobes stay up until idle, so calls chain back to back
////////////////////////////////////////
`timescale 1ns/1ps
`default_nettype none
module pmcfg_host_model (
   input wire logic clk,
   input wire logic [7:0] reg_rd_data,
   output logic reg_wr_en,
   output logic reg_rd_en,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wr_data
);
   initial begin
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      reg_addr = 8'h00;
      reg_wr_data = 8'h00;
   end
   task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
      reg_rd_en = 1'b0;
      reg_wr_en = 1'b1;
      reg_addr = a;
      reg_wr_data = d;
      @(posedge clk);
      #1;
   endtask : write_byte
   task automatic read_byte(input logic [7:0] a, output logic [7:0] d);
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b1;
      reg_addr = a;
      @(posedge clk);
      #1;
      d = reg_rd_data;
   endtask : read_byte
   // Released data is inverted so stale bytes never look valid
   task automatic idle();
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      reg_wr_data = ~reg_wr_data;
      @(posedge clk);
      #1;
   endtask : idle
endmodule : pmcfg_host_model
`default_nettype wire

// >>> tb_pmic_mode_setting_cfg_regs.sv
// Purpose: Self-checking bench of the mode config bank
// Assumes: All register traffic comes from the host model
// Notes: Mode waits are bounded
////////////////////////////////////////
`timescale 1ns/1ps
`default_nettype none
module tb_pmic_mode_setting_cfg_regs import pmcfg_pkg::*; ;
   logic clk, reset, reg_wr_en, reg_rd_en, reg_hit, mode_in_scope, ship_mode;
   logic mode_select_pin_a, mode_select_pin_b, mode_select_bit_a, mode_select_bit_b;
   logic nb_ship_m0, nb_src_pins_m0, nb_lin_ofs_m1, nb_src_pins_hi;
   logic core_buck_en, system_buck_en, aon_reg_en, sys_linear_en;
   logic [1:0] nb_wd_m1, active_mode, watchdog_period;
   logic [3:0] nb_aon_code_m1, nb_enables_m1;
   logic [4:0] nb_lin_code_m1;
   logic [5:0] nb_core_code_m0;
   logic [7:0] reg_addr, reg_wr_data, reg_rd_data, otp_m0p2, otp_m0p3, otp_m1p0;
   logic [7:0] watchdog_seconds;
   logic [15:0] core_buck_mv, aon_reg_mv, sys_linear_mv;
   int checks, error_cnt;
   wire [3:0] en4 = {core_buck_en, system_buck_en, aon_reg_en, sys_linear_en};
   pmcfg_host_model i_host (.clk, .reg_rd_data, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wr_data);
   pmcfg_regs i_dut (.clk, .reset, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wr_data, .reg_rd_data,
      .reg_hit, .otp_m0p2, .otp_m0p3, .otp_m1p0, .mode_select_pin_a, .mode_select_pin_b,
      .mode_select_bit_a, .mode_select_bit_b, .nb_ship_m0, .nb_src_pins_m0, .nb_core_code_m0,
      .nb_aon_code_m1, .nb_enables_m1, .nb_wd_m1, .nb_lin_ofs_m1, .nb_lin_code_m1,
      .nb_src_pins_hi, .active_mode, .mode_in_scope, .core_buck_en, .system_buck_en, .aon_reg_en,
      .sys_linear_en, .ship_mode, .watchdog_period, .watchdog_seconds, .core_buck_mv,
      .aon_reg_mv, .sys_linear_mv);
   always #12.5 clk = ~clk;
   ////////////////////////////////////////
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      i_host.read_byte(a, d);
      chk(d, exp);
   endtask : rd_chk
   task automatic step(input int n);
      repeat (n) i_host.idle();
   endtask : step
   task automatic wait_mode(input logic [1:0] m);
      int i;
      i = 0;
      while (active_mode !== m && i < 8) begin
         step(1);
         i++;
      end
      chk(active_mode, m);
      step(1);
   endtask : wait_mode
   function automatic logic [15:0] mv(input logic [15:0] b, input logic [5:0] c, input logic [5:0] t);
      return b + 16'h0019 * {10'h000, (c > t) ? t : c};
   endfunction : mv
   task automatic results();
      $display("checks=%0d error_cnt=%0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : results
   ////////////////////////////////////////
   task automatic t_defaults();
      rd_chk(8'h24, 8'h4f);
      rd_chk(8'h25, 8'h39);
      rd_chk(8'h26, 8'h1c);
      chk(reg_hit, 1'b1);
      chk(en4, 4'hf);
      chk(aon_reg_mv, 16'h0708);
      chk(core_buck_mv, 16'h03e8);
      chk(sys_linear_mv, 16'h0ce4);
      chk(watchdog_seconds, 8'h00);
      step(1);
      $display("t_defaults done");
   endtask : t_defaults
   task automatic t_otp();
      {otp_m0p2, otp_m0p3, otp_m1p0} = {8'ha5, 8'hd2, 8'h3f};
      reset = 1'b1;
      step(2);
      reset = 1'b0;
      rd_chk(8'h24, 8'ha5);
      rd_chk(8'h25, 8'hd2);
      rd_chk(8'h26, 8'h3f);
      chk(en4, 4'h5);
      chk(watchdog_period, 2'h3);
      {otp_m0p2, otp_m0p3, otp_m1p0} = {8'h4f, 8'h39, 8'h1c};
      reset = 1'b1;
      step(2);
      reset = 1'b0;
      $display("t_otp done");
   endtask : t_otp
   task automatic t_rw();
      logic [7:0] pats [3] = '{8'h00, 8'hff, 8'h96};
      // back to back write and read
      for (int j = 0; j < 3; j++) begin
         for (int i = 0; i < 3; i++) begin
            i_host.write_byte(8'h24 + i[7:0], pats[j] ^ i[7:0]);
            rd_chk(8'h24 + i[7:0], pats[j] ^ i[7:0]);
         end
      end
      i_host.write_byte(8'h27, 8'h5a);
      rd_chk(8'h27, 8'h00);
      chk(reg_hit, 1'b0);
      rd_chk(8'h26, 8'h94);
      step(1);
      $display("t_rw done");
   endtask : t_rw
   task automatic t_m0();
      logic [7:0] wd_s [4] = '{8'h00, 8'h10, 8'h20, 8'h40};
      for (int c = 0; c < 16; c++) begin
         i_host.write_byte(8'h24, {c[3:0], c[3:0]});
         step(1);
         chk(en4, c[3:0]);
         chk(aon_reg_mv, mv(16'h06a4, {2'h0, c[3:0]}, 6'h08));
      end
      for (int c = 0; c < 32; c++) begin
         i_host.write_byte(8'h25, {c[1:0], c[2], c[4:0]});
         step(1);
         chk(sys_linear_mv, mv(16'h05dc, {1'b0, c[4:0]}, 6'h18)
            + (c[2] ? 16'h04b0 : 16'h0000));
         chk(watchdog_period, c[1:0]);
         chk(watchdog_seconds, wd_s[c[1:0]]);
      end
      nb_ship_m0 = 1'b1;
      step(2);
      chk(ship_mode, 1'b1);
      nb_ship_m0 = 1'b0;
      $display("t_m0 done");
   endtask : t_m0
   task automatic t_m1();
      logic [5:0] codes [6] = '{6'h00, 6'h1c, 6'h28, 6'h29, 6'h3e, 6'h3f};
      mode_select_bit_a = 1'b1;
      wait_mode(2'h1);
      chk(mode_in_scope, 1'b1);
      for (int i = 0; i < 6; i++) begin
         i_host.write_byte(8'h26, {codes[i][0], 1'b0, codes[i]});
         step(1);
         chk(ship_mode, codes[i][0]);
         chk(core_buck_mv, (codes[i] == 6'h3f) ? 16'h0708
            : mv(16'h01f4, codes[i], 6'h28));
      end
      i_host.write_byte(8'h24, 8'h00);
      nb_wd_m1 = 2'h3;
      step(1);
      chk(en4, 4'h5);
      chk(aon_reg_mv, 16'h06ef);
      chk(watchdog_seconds, 8'h40);
      rd_chk(8'h24, 8'h00);
      step(1);
      $display("t_m1 done");
   endtask : t_m1
   task automatic t_source();
      mode_select_pin_b = 1'b1;
      step(6);
      chk(active_mode, 2'h1);
      mode_select_pin_b = 1'b0;
      mode_select_pin_a = 1'b1;
      step(3);
      i_host.write_byte(8'h26, 8'h40);
      mode_select_bit_a = 1'b0;
      step(6);
      chk(active_mode, 2'h1);
      mode_select_pin_a = 1'b0;
      wait_mode(2'h0);
      // mode 2 applies no enables and no watchdog
      mode_select_bit_b = 1'b1;
      wait_mode(2'h2);
      chk(mode_in_scope, 1'b0);
      chk(en4, 4'h0);
      chk(watchdog_seconds, 8'h00);
      mode_select_bit_b = 1'b0;
      wait_mode(2'h0);
      $display("t_source done");
   endtask : t_source
   ////////////////////////////////////////
   initial begin
      clk = 1'b0;
      reset = 1'b1;
      {mode_select_pin_a, mode_select_pin_b, mode_select_bit_a, mode_select_bit_b} = 4'h0;
      {nb_ship_m0, nb_src_pins_m0, nb_lin_ofs_m1, nb_src_pins_hi} = 4'h0;
      nb_wd_m1 = 2'h1;
      nb_aon_code_m1 = 4'h3;
      nb_enables_m1 = 4'h5;
      nb_lin_code_m1 = 5'h0c;
      nb_core_code_m0 = 6'h14;
      {otp_m0p2, otp_m0p3, otp_m1p0} = {8'h4f, 8'h39, 8'h1c};
      repeat (2) @(posedge clk);
      #1;
      reset = 1'b0;
      t_defaults();
      t_otp();
      t_rw();
      t_m0();
      t_m1();
      t_source();
      results();
   end
   // Hang guard, far beyond the few hundred cycles the tests need
   initial begin
      #50000;
      error_cnt++;
      results();
   end
endmodule : tb_pmic_mode_setting_cfg_regs
`default_nettype wire
